// >>> sys_flag_regs.vh
// register offsets, field positions, reset values and timing counts of the flag bank
`ifndef SYS_FLAG_REGS_VH
`define SYS_FLAG_REGS_VH

// register byte offsets
`define REG_FLAGS 8'h00
`define REG_CTRL 8'h04
`define REG_CLK_W0 8'h08
`define REG_CLK_W1 8'h0c
`define REG_CLK_W2 8'h10
`define REG_CLK_W3 8'h14
`define REG_WDT_CAUSE 8'h18
`define REG_TEST_ERR0 8'h1c
`define REG_TEST_ERR1 8'h20
`define REG_CFG 8'h24

// status register bit positions
`define FLG_FUSE 0
`define FLG_SUPPLY_DOWN 1
`define FLG_BATT_LIVE 2
`define FLG_BATT_LATCH 3
`define FLG_SELF_DIAG 4
`define FLG_DIAG 5
`define FLG_CLK_ERR 6
`define FLG_ONE 7
`define FLG_ZERO 8
`define FLG_WDT 9
`define FLG_READY 10
`define FLG_TEST_ACT 11
`define FLG_FSTOP 12
`define FLG_TEST_ERR 13
`define FLG_WIDTH 14

// control register bit positions
`define CTL_CLK_SET 0
`define CTL_CLK_READ 1
`define CTL_ERR_REL 2

// configuration register bit positions
`define CFG_BATT_USE 0
`define CFG_SUPPLY_AC 1

// reset values
`define CTRL_RST 3'h0
`define CFG_RST 2'h0
`define WORD_RST 16'h0000

// timing
`define CLK_PERIOD_NS 4
`define AC_DOWN_MS 20
`define DC_DOWN_MS 10
`define OP_CYCLE_US 1
`define AC_DOWN_CYC ((`AC_DOWN_MS * 1000000) / `CLK_PERIOD_NS)
`define DC_DOWN_CYC ((`DC_DOWN_MS * 1000000) / `CLK_PERIOD_NS)
`define OP_CYCLE_CYC ((`OP_CYCLE_US * 1000) / `CLK_PERIOD_NS)
`define DOWN_CNT_W 23

`endif

// >>> cycle_tick.v
// enable pulse divider that marks each operation cycle
`timescale 1ns/1ps
module cycle_tick #(
	parameter DIV = 250
) (
	input wire i_clk,
	input wire i_rst,
	output wire o_tick
);
	reg [15:0] cnt_ff;
	// full-width terminal count, cut to the counter width on purpose
	wire [31:0] last_full = DIV - 1;
	wire [15:0] last = last_full[15:0];

	// count up the cycle period, pulse on wrap
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= 16'h0000;
		end else if (cnt_ff == last) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	assign o_tick = (cnt_ff == last);
endmodule

// >>> system_status_flag_bank.v
// system status and request flag bank of the motion controller
//
// Function
// - fuse-blown flag sets on any blown output fuse and stays set.
// - AC supply: outage shorter than 20 ms sets supply-down; only power cycle clears.
// - DC supply: outage shorter than 10 ms sets supply-down flag.
// - live battery-low flag follows battery, drives indicator, only when battery used.
// - latched battery-low flag sets on low voltage and stays set.
// - self-diagnostic error flag sets on self-diagnosis error and stays set.
// - diagnostic error flag sets on any diagnosis error and stays set.
// - rising clock-set request writes four clock words once; holding it does nothing.
// - invalid clock words presented for setting raise the clock-data error flag.
// - while clock-read request is held, clock words keep loading current BCD time.
// - one constant-one bit and one constant-zero bit, always maintained.
// - rising error-release bit clears the current error condition.
// - watchdog error sets flag, stops axes at once, records cause word.
// - rising controller-ready checks parameters; ready-complete sets only without errors.
// - ready-complete clears whenever controller-ready turns off.
// - test-mode flag is set while peripheral-requested test mode is in effect.
// - refused test-mode request keeps flag clear and sets request error flag.
// - forced-stop input sampled each operation cycle, shown inverted.
// - test-mode request error stores its content in two error words.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "sys_flag_regs.vh"
module system_status_flag_bank #(
	parameter AC_DOWN_CYC = `AC_DOWN_CYC,
	parameter DC_DOWN_CYC = `DC_DOWN_CYC,
	parameter OP_CYCLE_CYC = `OP_CYCLE_CYC
) (
	input wire i_clk,
	input wire i_rst,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output wire [31:0] o_rdata,
	input wire i_fuse_blown,
	input wire i_supply_ok,
	input wire i_battery_low,
	input wire i_self_diag_err,
	input wire i_diag_err,
	input wire i_wdt_err,
	input wire [15:0] i_wdt_cause,
	input wire i_controller_ready_input,
	input wire i_param_err,
	input wire i_test_mode_req,
	input wire i_test_mode_ok,
	input wire [15:0] i_test_err_data0,
	input wire [15:0] i_test_err_data1,
	input wire i_forced_stop_active,
	input wire [63:0] i_rtc_now,
	output wire [63:0] o_rtc_data,
	output wire o_rtc_set,
	output wire o_battery_indicator,
	output wire o_axis_stop_now,
	output wire o_ready_complete
);
	// one-hot states of the supply watcher
	localparam ST_UP = 2'b01;
	localparam ST_DOWN = 2'b10;

	reg [31:0] rdata_ff;
	reg [2:0] ctrl_ff;
	reg [2:0] ctrl_prev_ff;
	reg [1:0] cfg_ff;
	reg [15:0] clk_w0_ff;
	reg [15:0] clk_w1_ff;
	reg [15:0] clk_w2_ff;
	reg [15:0] clk_w3_ff;
	reg [15:0] wdt_cause_ff;
	reg [15:0] test_err0_ff;
	reg [15:0] test_err1_ff;
	reg rtc_set_ff;
	reg [1:0] sup_state_ff;
	reg [`DOWN_CNT_W-1:0] down_cnt_ff;
	reg output_fuse_blown_flag_ff;
	reg supply_down_flag_ff;
	reg battery_low_live_flag_ff;
	reg battery_low_latched_flag_ff;
	reg self_diag_error_flag_ff;
	reg diag_error_flag_ff;
	reg clock_data_error_flag_ff;
	reg watchdog_error_flag_ff;
	reg ready_complete_flag_ff;
	reg ready_prev_ff;
	reg test_mode_active_flag_ff;
	reg test_req_prev_ff;
	reg test_mode_request_error_flag_ff;
	reg forced_stop_input_flag_ff;
	wire op_tick;
	wire wr_ctrl;
	wire clock_set_request_bit;
	wire clock_read_request_bit;
	wire error_release_bit;
	wire set_rise;
	wire err_release;
	wire clk_words_ok;
	wire [`DOWN_CNT_W-1:0] down_limit;
	wire momentary;
	wire ready_rise;
	wire test_req_rise;
	wire test_refused;
	wire [`FLG_WIDTH-1:0] flags;

	// true when every nibble of a word is a decimal digit
	function bcd_ok;
		input [15:0] w;
		begin
			bcd_ok = (w[3:0] < 4'ha) && (w[7:4] < 4'ha) &&
				(w[11:8] < 4'ha) && (w[15:12] < 4'ha);
		end
	endfunction

	// operation cycle enable
	cycle_tick #(
		.DIV(OP_CYCLE_CYC)
	) u_op_tick (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.o_tick(op_tick)
	);

	// user request bits and their edges
	assign wr_ctrl = i_wr && (i_addr == `REG_CTRL);
	assign clock_set_request_bit = ctrl_ff[`CTL_CLK_SET];
	assign clock_read_request_bit = ctrl_ff[`CTL_CLK_READ];
	assign error_release_bit = ctrl_ff[`CTL_ERR_REL];
	assign set_rise = clock_set_request_bit && !ctrl_prev_ff[`CTL_CLK_SET];
	assign err_release = error_release_bit && !ctrl_prev_ff[`CTL_ERR_REL];

	// control and configuration registers
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_ff <= `CTRL_RST;
			ctrl_prev_ff <= `CTRL_RST;
			cfg_ff <= `CFG_RST;
		end else begin
			ctrl_prev_ff <= ctrl_ff;
			if (wr_ctrl) begin
				ctrl_ff <= i_wdata[2:0];
			end
			if (i_wr && (i_addr == `REG_CFG)) begin
				cfg_ff <= i_wdata[1:0];
			end
		end
	end

	// clock data words: software writes, read request reloads them
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			clk_w0_ff <= `WORD_RST;
			clk_w1_ff <= `WORD_RST;
			clk_w2_ff <= `WORD_RST;
			clk_w3_ff <= `WORD_RST;
		end else if (clock_read_request_bit) begin
			// clock element time in bcd, reloaded every cycle
			clk_w0_ff <= i_rtc_now[15:0];
			clk_w1_ff <= i_rtc_now[31:16];
			clk_w2_ff <= i_rtc_now[47:32];
			clk_w3_ff <= i_rtc_now[63:48];
		end else if (i_wr) begin
			if (i_addr == `REG_CLK_W0) begin
				clk_w0_ff <= i_wdata[15:0];
			end
			if (i_addr == `REG_CLK_W1) begin
				clk_w1_ff <= i_wdata[15:0];
			end
			if (i_addr == `REG_CLK_W2) begin
				clk_w2_ff <= i_wdata[15:0];
			end
			if (i_addr == `REG_CLK_W3) begin
				clk_w3_ff <= i_wdata[15:0];
			end
		end
	end

	// validity of the words offered to the clock element
	assign clk_words_ok = bcd_ok(clk_w0_ff) && bcd_ok(clk_w1_ff) &&
		bcd_ok(clk_w2_ff) && bcd_ok(clk_w3_ff);

	// one write pulse per off-to-on edge, bad data never written
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rtc_set_ff <= 1'b0;
		end else begin
			rtc_set_ff <= set_rise && clk_words_ok;
		end
	end

	assign o_rtc_set = rtc_set_ff;
	assign o_rtc_data = {clk_w3_ff, clk_w2_ff, clk_w1_ff, clk_w0_ff};

	// clock data error: set on bad words, released by error release
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			clock_data_error_flag_ff <= 1'b0;
		end else if (set_rise && !clk_words_ok) begin
			clock_data_error_flag_ff <= 1'b1;
		end else if (err_release) begin
			clock_data_error_flag_ff <= 1'b0;
		end
	end

	// outage length limit picked by supply type
	assign down_limit = cfg_ff[`CFG_SUPPLY_AC] ?
		AC_DOWN_CYC[`DOWN_CNT_W-1:0] :
		DC_DOWN_CYC[`DOWN_CNT_W-1:0];
	assign momentary = (down_cnt_ff < down_limit);

	// supply watcher: time each outage, flag short ones
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sup_state_ff <= ST_UP;
			down_cnt_ff <= {`DOWN_CNT_W{1'b0}};
			supply_down_flag_ff <= 1'b0;
		end else begin
			case (sup_state_ff)
				ST_UP: begin
					down_cnt_ff <= {`DOWN_CNT_W{1'b0}};
					if (!i_supply_ok) begin
						sup_state_ff <= ST_DOWN;
					end
				end
				ST_DOWN: begin
					if (i_supply_ok) begin
						sup_state_ff <= ST_UP;
						if (momentary) begin
							// only reset (power cycle) clears it
							supply_down_flag_ff <= 1'b1;
						end
					end else if (momentary) begin
						down_cnt_ff <= down_cnt_ff + {{(`DOWN_CNT_W-1){1'b0}}, 1'b1};
					end
				end
				default: begin
					sup_state_ff <= ST_UP;
				end
			endcase
		end
	end

	// fault flags, sticky except the live battery flag, updated every clock cycle
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			output_fuse_blown_flag_ff <= 1'b0;
			battery_low_live_flag_ff <= 1'b0;
			battery_low_latched_flag_ff <= 1'b0;
			self_diag_error_flag_ff <= 1'b0;
			diag_error_flag_ff <= 1'b0;
		end else begin
			if (i_fuse_blown) begin
				output_fuse_blown_flag_ff <= 1'b1;
			end else if (err_release) begin
				output_fuse_blown_flag_ff <= 1'b0;
			end
			// live flag only watches battery when it is in use
			battery_low_live_flag_ff <= cfg_ff[`CFG_BATT_USE] && i_battery_low;
			if (cfg_ff[`CFG_BATT_USE] && i_battery_low) begin
				battery_low_latched_flag_ff <= 1'b1;
			end
			if (i_self_diag_err) begin
				self_diag_error_flag_ff <= 1'b1;
			end else if (err_release) begin
				self_diag_error_flag_ff <= 1'b0;
			end
			if (i_diag_err || i_self_diag_err) begin
				diag_error_flag_ff <= 1'b1;
			end else if (err_release) begin
				diag_error_flag_ff <= 1'b0;
			end
		end
	end

	assign o_battery_indicator = battery_low_live_flag_ff;

	// watchdog: flag, cause capture and immediate axis stop
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			watchdog_error_flag_ff <= 1'b0;
			wdt_cause_ff <= `WORD_RST;
		end else if (i_wdt_err) begin
			watchdog_error_flag_ff <= 1'b1;
			wdt_cause_ff <= i_wdt_cause;
		end else if (err_release) begin
			watchdog_error_flag_ff <= 1'b0;
		end
	end

	assign o_axis_stop_now = watchdog_error_flag_ff;

	// ready complete follows controller-ready after a clean check
	assign ready_rise = i_controller_ready_input && !ready_prev_ff;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ready_prev_ff <= 1'b0;
			ready_complete_flag_ff <= 1'b0;
		end else begin
			ready_prev_ff <= i_controller_ready_input;
			if (!i_controller_ready_input) begin
				ready_complete_flag_ff <= 1'b0;
			end else if (ready_rise) begin
				ready_complete_flag_ff <= !i_param_err;
			end
		end
	end

	assign o_ready_complete = ready_complete_flag_ff;

	// test mode: active while granted, error and data on refusal
	assign test_req_rise = i_test_mode_req && !test_req_prev_ff;
	assign test_refused = test_req_rise && !i_test_mode_ok;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			test_req_prev_ff <= 1'b0;
			test_mode_active_flag_ff <= 1'b0;
			test_mode_request_error_flag_ff <= 1'b0;
			test_err0_ff <= `WORD_RST;
			test_err1_ff <= `WORD_RST;
		end else begin
			test_req_prev_ff <= i_test_mode_req;
			test_mode_active_flag_ff <= i_test_mode_req && i_test_mode_ok;
			if (test_refused) begin
				test_mode_request_error_flag_ff <= 1'b1;
				test_err0_ff <= i_test_err_data0;
				test_err1_ff <= i_test_err_data1;
			end else if (err_release) begin
				test_mode_request_error_flag_ff <= 1'b0;
			end
		end
	end

	// forced stop sampled once per operation cycle, inverted
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			forced_stop_input_flag_ff <= 1'b0;
		end else if (op_tick) begin
			forced_stop_input_flag_ff <= !i_forced_stop_active;
		end
	end

	// status word, constants tied in
	assign flags = {
		test_mode_request_error_flag_ff,
		forced_stop_input_flag_ff,
		test_mode_active_flag_ff,
		ready_complete_flag_ff,
		watchdog_error_flag_ff,
		1'b0, // constant zero
		1'b1, // constant one
		clock_data_error_flag_ff,
		diag_error_flag_ff,
		self_diag_error_flag_ff,
		battery_low_latched_flag_ff,
		battery_low_live_flag_ff,
		supply_down_flag_ff,
		output_fuse_blown_flag_ff
	};

	// read port: data valid one cycle after the strobe, zero otherwise
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= 32'h00000000;
		end else if (i_rd) begin
			case (i_addr)
				`REG_FLAGS: rdata_ff <= {18'h00000, flags};
				`REG_CTRL: rdata_ff <= {29'h00000000, ctrl_ff};
				`REG_CLK_W0: rdata_ff <= {16'h0000, clk_w0_ff};
				`REG_CLK_W1: rdata_ff <= {16'h0000, clk_w1_ff};
				`REG_CLK_W2: rdata_ff <= {16'h0000, clk_w2_ff};
				`REG_CLK_W3: rdata_ff <= {16'h0000, clk_w3_ff};
				`REG_WDT_CAUSE: rdata_ff <= {16'h0000, wdt_cause_ff};
				`REG_TEST_ERR0: rdata_ff <= {16'h0000, test_err0_ff};
				`REG_TEST_ERR1: rdata_ff <= {16'h0000, test_err1_ff};
				`REG_CFG: rdata_ff <= {30'h00000000, cfg_ff};
				default: rdata_ff <= 32'h00000000;
			endcase
		end else begin
			rdata_ff <= 32'h00000000;
		end
	end

	assign o_rdata = rdata_ff;
endmodule

// >>> flag_bank_asserts.sv
// concurrent checks on the flag bank ports
`timescale 1ns/1ps
`include "sys_flag_regs.vh"
module flag_bank_asserts (
	input logic i_clk,
	input logic i_rst,
	input logic [7:0] i_addr,
	input logic [31:0] i_wdata,
	input logic i_wr,
	input logic i_rd,
	input logic [31:0] o_rdata,
	input logic i_battery_low,
	input logic i_wdt_err,
	input logic i_controller_ready_input,
	input logic i_param_err,
	input logic o_rtc_set,
	input logic o_battery_indicator,
	input logic o_axis_stop_now,
	input logic o_ready_complete
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// helper strobes
	wire set_wr = i_wr && i_addr == `REG_CTRL && i_wdata[`CTL_CLK_SET];
	wire flag_rd = i_rd && i_addr == `REG_FLAGS;
	sequence set_req;
		set_wr;
	endsequence
	sequence ready_good;
		$rose(i_controller_ready_input) && !i_param_err;
	endsequence
	sequence ready_bad;
		$rose(i_controller_ready_input) && i_param_err;
	endsequence
	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not idle");
	chk_const_bits: assert property ($past(flag_rd) |-> o_rdata[8:7] == 2'h1)
		else $error("constant bits wrong");
	chk_rtc_single: assert property (o_rtc_set |=> !o_rtc_set)
		else $error("clock set pulse too long");
	chk_rtc_cause: assert property (o_rtc_set |-> $past(set_wr, 2))
		else $error("clock set without request");
	chk_wdt_stop: assert property (i_wdt_err |-> ##[1:2] o_axis_stop_now)
		else $error("axes not stopped");
	chk_ready_set: assert property (ready_good |-> ##[1:2] o_ready_complete)
		else $error("ready not complete");
	chk_ready_fail: assert property (ready_bad |=> !o_ready_complete [*2])
		else $error("ready set despite error");
	chk_ready_off: assert property (!i_controller_ready_input [*3] |-> !o_ready_complete)
		else $error("ready stays on");
	chk_batt_follow: assert property (o_battery_indicator |->
		$past(i_battery_low) || $past(i_battery_low, 2))
		else $error("indicator without low battery");
	cover property (set_req ##2 o_rtc_set);
endmodule

// >>> peer_model.sv
// clock element and peripheral test device beside the flag bank
`timescale 1ns/1ps
module peer_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_want,
	input wire logic i_grant,
	input wire logic i_rtc_set,
	input wire logic [63:0] i_rtc_data,
	output logic [63:0] o_rtc_now,
	output logic o_test_req,
	output logic o_test_ok,
	output logic [15:0] o_err0,
	output logic [15:0] o_err1
);
	// clock element keeps the last time written to it
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rtc_now <= 64'h0;
		end else if (i_rtc_set) begin
			o_rtc_now <= i_rtc_data;
		end
	end
	// test device changes request and grant after an edge
	always @(posedge i_clk) begin
		o_test_req <= i_want;
		o_test_ok <= i_grant;
	end
	// refusal detail words
	assign o_err0 = 16'h0b17;
	assign o_err1 = 16'h00c3;
endmodule

// >>> tb.sv
// self-checking bench of the flag bank
`timescale 1ns/1ps
`include "sys_flag_regs.vh"
module tb;
	logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, want = 0, grant = 0;
	logic [7:0] i_addr = 0;
	logic [31:0] i_wdata = 0, v;
	logic i_fuse_blown = 0, i_supply_ok = 1, i_battery_low = 0, i_self_diag_err = 0;
	logic i_diag_err = 0, i_wdt_err = 0, i_controller_ready_input = 0, i_param_err = 0;
	logic i_forced_stop_active = 0;
	logic [15:0] i_wdt_cause = 16'h0000;
	logic [15:0] w [4] = '{16'h0059, 16'h2312, 16'h0715, 16'h0024};
	wire [31:0] o_rdata;
	wire [63:0] o_rtc_data, i_rtc_now;
	wire [15:0] i_test_err_data0, i_test_err_data1;
	wire o_rtc_set, o_battery_indicator, o_axis_stop_now, o_ready_complete;
	wire i_test_mode_req, i_test_mode_ok;
	int errors = 0, tests_run = 0, pulses = 0, k;
	always #2 i_clk = ~i_clk;
	system_status_flag_bank #(.AC_DOWN_CYC(40), .DC_DOWN_CYC(20), .OP_CYCLE_CYC(8)) uut (.*);
	peer_model peer (.i_clk(i_clk), .i_rst(i_rst), .i_want(want), .i_grant(grant),
		.i_rtc_set(o_rtc_set), .i_rtc_data(o_rtc_data), .o_rtc_now(i_rtc_now),
		.o_test_req(i_test_mode_req), .o_test_ok(i_test_mode_ok),
		.o_err0(i_test_err_data0), .o_err1(i_test_err_data1));
	// count clock-set pulses
	always @(posedge i_clk) if (o_rtc_set === 1'b1) pulses <= pulses + 1;
	task give_verdict;
		if (errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input string s, input [63:0] e, input [63:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task rf(input [31:0] m, input [31:0] e);
		rd(`REG_FLAGS);
		chk("flags", e, v & m);
	endtask
	task do_rst;
		i_rst <= 1'b1;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
	endtask
	task outage(input int n);
		i_supply_ok <= 1'b0;
		repeat (n) @(posedge i_clk);
		i_supply_ok <= 1'b1;
		repeat (3) @(posedge i_clk);
	endtask
	// hang guard
	initial begin
		#200000;
		errors++;
		give_verdict;
	end
	initial begin
		do_rst;
		rf(32'hffffefff, 32'h80);
		rd(`REG_CTRL);
		chk("ctrl", 0, v);
		rd(8'h28);
		chk("unmapped", 0, v);
		outage(30);
		rf(32'h2, 32'h0);
		outage(10);
		rf(32'h2, 32'h2);
		do_rst;
		rf(32'h2, 32'h0);
		wr(`REG_CFG, 32'h3);
		outage(60);
		rf(32'h2, 32'h0);
		outage(30);
		rf(32'h2, 32'h2);
		// battery low then recovered
		i_battery_low <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk("indicator", 1, o_battery_indicator);
		rf(32'hc, 32'hc);
		i_battery_low <= 1'b0;
		repeat (3) @(posedge i_clk);
		rf(32'hc, 32'h8);
		chk("indicator", 0, o_battery_indicator);
		// error sources pulse then go quiet
		{i_fuse_blown, i_self_diag_err, i_diag_err, i_wdt_err} <= 4'hf;
		i_wdt_cause <= 16'h1234;
		repeat (2) @(posedge i_clk);
		{i_fuse_blown, i_self_diag_err, i_diag_err, i_wdt_err} <= 4'h0;
		repeat (2) @(posedge i_clk);
		chk("axis stop", 1, o_axis_stop_now);
		rf(32'h231, 32'h231);
		rd(`REG_WDT_CAUSE);
		chk("wdt cause", 32'h1234, v);
		wr(`REG_CTRL, 32'h4);
		wr(`REG_CTRL, 32'h0);
		rf(32'h27b, 32'ha);
		chk("axis stop", 0, o_axis_stop_now);
		// forced stop sampled per operation cycle
		i_forced_stop_active <= 1'b1;
		repeat (20) @(posedge i_clk);
		rf(32'h1000, 32'h0);
		i_forced_stop_active <= 1'b0;
		repeat (20) @(posedge i_clk);
		rf(32'h1000, 32'h1000);
		// ready with failing then passing check
		i_param_err <= 1'b1;
		i_controller_ready_input <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk("ready", 0, o_ready_complete);
		i_controller_ready_input <= 1'b0;
		i_param_err <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_controller_ready_input <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk("ready", 1, o_ready_complete);
		rf(32'h400, 32'h400);
		i_controller_ready_input <= 1'b0;
		repeat (3) @(posedge i_clk);
		chk("ready", 0, o_ready_complete);
		// clock set with valid words, then invalid
		for (k = 0; k < 4; k++) wr(`REG_CLK_W0 + 8'(4 * k), {16'h0, w[k]});
		wr(`REG_CTRL, 32'h1);
		k = 0;
		while (o_rtc_set !== 1'b1 && k < 8) begin
			@(posedge i_clk);
			#1 k++;
		end
		if (k == 8) begin
			errors++;
			give_verdict;
		end
		chk("rtc data", {w[3], w[2], w[1], w[0]}, o_rtc_data);
		repeat (8) @(posedge i_clk);
		wr(`REG_CLK_W0, 32'h00a0);
		wr(`REG_CTRL, 32'h0);
		wr(`REG_CTRL, 32'h1);
		repeat (3) @(posedge i_clk);
		rf(32'h40, 32'h40);
		chk("set pulses", 1, pulses);
		// read request reloads words from the clock element
		wr(`REG_CTRL, 32'h2);
		repeat (3) @(posedge i_clk);
		rd(`REG_CLK_W0);
		chk("clock w0", 32'h0059, v);
		rd(`REG_CLK_W3);
		chk("clock w3", 32'h0024, v);
		wr(`REG_CTRL, 32'h0);
		// granted then refused test mode
		grant <= 1'b1;
		want <= 1'b1;
		repeat (4) @(posedge i_clk);
		rf(32'h2800, 32'h800);
		want <= 1'b0;
		repeat (4) @(posedge i_clk);
		rf(32'h2800, 32'h0);
		grant <= 1'b0;
		want <= 1'b1;
		repeat (4) @(posedge i_clk);
		rf(32'h2800, 32'h2000);
		rd(`REG_TEST_ERR0);
		chk("test err0", 32'h0b17, v);
		rd(`REG_TEST_ERR1);
		chk("test err1", 32'h00c3, v);
		give_verdict;
	end
endmodule
bind system_status_flag_bank flag_bank_asserts chk_i (.*);
